// [logic/cpfm_defs.vh]
`ifndef CPFM_DEFS_VH
`define CPFM_DEFS_VH
// Register map
`define CPFM_ADDR_W          8
`define CPFM_OFS_CFG1        8'h00
`define CPFM_OFS_STATUS      8'h01
`define CPFM_OFS_TOFF        8'h02
`define CPFM_OFS_PROP        8'h03
`define CPFM_CFG1_RESET      8'h43
`define CPFM_STATUS_RESET    8'hff
`define CPFM_TOFF_RESET      8'h00
`define CPFM_PROP_RESET      8'h00
// Configuration bits
`define CPFM_BIT_TRE         7
`define CPFM_BIT_PVE         6
`define CPFM_BIT_TRC         5
`define CPFM_BIT_OTC         4
`define CPFM_BIT_OCC         3
`define CPFM_BIT_UVC         2
`define CPFM_BIT_OVC         1
`define CPFM_BIT_PVC         0
// Fault indices, same order as latch bits
`define CPFM_NFLT            6
`define CPFM_F_TR            5
`define CPFM_F_OT            4
`define CPFM_F_OC            3
`define CPFM_F_UV            2
`define CPFM_F_OV            1
`define CPFM_F_PV            0
// Turn-off styles
`define CPFM_STY_SEQ         2'd0
`define CPFM_STY_CRIT        2'd1
`define CPFM_STY_EMER        2'd2
// Style fields in turn-off register
`define CPFM_TOFF_OT_LSB     0
`define CPFM_TOFF_UV_LSB     2
`define CPFM_TOFF_OV_LSB     4
// Thresholds, temperature in degC, voltage in mV
`define CPFM_TEMP_W          9
`define CPFM_OT_TRIP_C       9'd130
`define CPFM_OT_CLEAR_C      9'd120
`define CPFM_MV_W            13
`define CPFM_TRACK_MV        13'd250
`define CPFM_OV_FLOOR_MV     13'd500
`define CPFM_OV_MARGIN_MV    13'd250
`define CPFM_OV_PCT_MIN      8'd110
`define CPFM_OV_PCT_MAX      8'd130
`define CPFM_PCT_DIV         13'd100
// Retry interval
`define CPFM_RETRY_MS        130
`define CPFM_CLK_KHZ         200000
`define CPFM_CNT_W           25
`define CPFM_RETRY_CYCLES    25'd26000000
`endif

// [logic/cpfm_retry_timer.v]
`timescale 1ns/100ps
`default_nettype none
`include "cpfm_defs.vh"
module cpfm_retry_timer #(
  parameter [`CPFM_CNT_W-1:0] RETRY_CYCLES = `CPFM_RETRY_CYCLES
) (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Control
  input  wire start,
  output wire done
);
  reg [`CPFM_CNT_W-1:0] cnt_r;
  reg                   run_r;
  reg [`CPFM_CNT_W-1:0] cnt_nxt;
  reg                   run_nxt;

  assign done = run_r && (cnt_r == {`CPFM_CNT_W{1'b0}});

  always @* begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (start) begin
      cnt_nxt = RETRY_CYCLES - {{(`CPFM_CNT_W-1){1'b0}}, 1'b1};
      run_nxt = 1'b1;
    end else if (run_r && cnt_r != {`CPFM_CNT_W{1'b0}}) begin
      cnt_nxt = cnt_r - {{(`CPFM_CNT_W-1){1'b0}}, 1'b1};
    end else if (done) begin
      run_nxt = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      cnt_r <= {`CPFM_CNT_W{1'b0}};
      run_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end
endmodule // cpfm_retry_timer
`default_nettype wire

// [logic/cpfm_ov_limit.v]
`timescale 1ns/100ps
`default_nettype none
`include "cpfm_defs.vh"
module cpfm_ov_limit (
  // Setpoint and programmed percentage
  input  wire [`CPFM_MV_W-1:0] setpoint_mv,
  input  wire [7:0]            ov_pct,
  // Resulting threshold
  output wire [`CPFM_MV_W-1:0] ov_limit_mv
);
  wire [7:0]              pct_clamped;
  wire [`CPFM_MV_W+7:0]   prod;
  wire [`CPFM_MV_W+7:0]   quot;
  wire [`CPFM_MV_W-1:0]   scaled;
  wire [`CPFM_MV_W-1:0]   min_above;
  wire [`CPFM_MV_W-1:0]   lim_a;

  assign pct_clamped = (ov_pct < `CPFM_OV_PCT_MIN) ? `CPFM_OV_PCT_MIN :
                       (ov_pct > `CPFM_OV_PCT_MAX) ? `CPFM_OV_PCT_MAX : ov_pct;
  assign prod        = setpoint_mv * pct_clamped;
  assign quot        = prod / `CPFM_PCT_DIV;
  assign scaled      = quot[`CPFM_MV_W-1:0];
  assign min_above   = setpoint_mv + `CPFM_OV_MARGIN_MV;
  assign lim_a       = (scaled < min_above) ? min_above : scaled;
  assign ov_limit_mv = (lim_a < `CPFM_OV_FLOOR_MV) ? `CPFM_OV_FLOOR_MV : lim_a;
endmodule // cpfm_ov_limit
`default_nettype wire

// [logic/cpfm_fault_mgr.v]
// Functional notes
// - Above 130 C: overtemp fault, ramped turn-off
// - Non-latching overtemp restarts below 120 C
// - Tracking checked only during ramp-up
// - Tracking error over 250mV: fast off
// - Config bit 7 enables tracking protection
// - Limits follow margined setpoint; no tracking then
// - Overvoltage above pre-bias: turn off, flag
// - Overvoltage: high side off, low side on in emergency style
// - OV limit 110-130%, >=0.5V, >=setpoint+0.25V
// - Non-latching: retry every 130ms until cleared
// - Latching: stay off until cleared or recycled
// - Bits 5..0 select latching per protection
// - Config bit 6 enables phase voltage detection
// - Each protection has latch and propagate choice
// - Overtemp, undervolt, overvolt turn-off style selectable
// - Sequenced turn-off ramps down at set rate
// - Critical opens both; emergency closes low side
// - Propagating fault pulls shared fault line low
// - Overcurrent: flag cleared, both switches off
`timescale 1ns/100ps
`default_nettype none
`include "cpfm_defs.vh"
module cpfm_fault_mgr #(
  parameter [`CPFM_CNT_W-1:0] RETRY_CYCLES = `CPFM_RETRY_CYCLES
) (
  // Clock and reset
  input  wire                     clk,
  input  wire                     rst,
  // Register port
  input  wire [`CPFM_ADDR_W-1:0]  reg_addr,
  input  wire                     reg_wr,
  input  wire [7:0]               reg_wdata,
  output reg  [7:0]               reg_rdata,
  // Measurements and converter state
  input  wire [`CPFM_TEMP_W-1:0]  temp_c,
  input  wire [`CPFM_MV_W-1:0]    vout_mv,
  input  wire [`CPFM_MV_W-1:0]    vramp_mv,
  input  wire [`CPFM_MV_W-1:0]    setpoint_mv,
  input  wire [7:0]               ov_pct,
  input  wire                     above_prebias,
  input  wire                     ramping_up,
  input  wire                     margin_change,
  input  wire                     overcurrent_fault,
  input  wire                     undervoltage_fault,
  input  wire                     phase_voltage_fault,
  input  wire                     turn_on_cmd,
  // Power stage and sequencer
  output reg                      run_enable,
  output reg                      ramp_down_req,
  output reg                      high_side_en,
  output reg                      low_side_force,
  output reg                      retry_pulse,
  // Shared fault line, open drain
  input  wire                     fault_line_in,
  output reg                      fault_line_out,
  output reg                      fault_line_oe_n,
  // Thresholds for monitoring
  output wire [`CPFM_MV_W-1:0]    ov_limit_mv
);
  localparam [3:0] ST_RUN   = 4'b0001;
  localparam [3:0] ST_RAMP  = 4'b0010;
  localparam [3:0] ST_OFF   = 4'b0100;
  localparam [3:0] ST_LATCH = 4'b1000;

  reg  [7:0]             cfg1_r;
  reg  [7:0]             status_r;
  reg  [7:0]             toff_r;
  reg  [7:0]             prop_r;
  reg  [3:0]             state_r;
  reg  [3:0]             state_nxt;
  reg  [1:0]             style_r;
  reg  [1:0]             style_nxt;
  reg  [`CPFM_NFLT-1:0]  cause_r;
  reg                    ot_hot_r;
  reg                    turn_on_d_r;
  reg                    track_blk_r;
  reg                    recycle_seen_r;
  reg                    interval_met_r;
  reg                    start_timer;
  wire                   timer_done;
  wire [`CPFM_NFLT-1:0]  trip;
  wire [`CPFM_NFLT-1:0]  cond;
  wire [`CPFM_NFLT-1:0]  latch_sel;
  wire [`CPFM_MV_W-1:0]  track_diff;
  wire                   any_trip;
  wire                   cause_latching;
  wire                   cause_cleared;
  wire                   status_ok;
  wire                   on_recycled;
  wire                   wr_status;
  wire                   ot_only;
  wire                   prop_hit;

  function [1:0] style_of;
    input [7:0] toff;
    input [5:0] flt;
    begin
      if (flt[`CPFM_F_OV])
        style_of = (style_field(toff, `CPFM_TOFF_OV_LSB) == `CPFM_STY_EMER) ? `CPFM_STY_EMER : `CPFM_STY_CRIT;
      else if (flt[`CPFM_F_TR] || flt[`CPFM_F_OC] || flt[`CPFM_F_PV])
        style_of = `CPFM_STY_CRIT;
      else if (flt[`CPFM_F_UV])
        style_of = style_field(toff, `CPFM_TOFF_UV_LSB);
      else
        style_of = style_field(toff, `CPFM_TOFF_OT_LSB);
    end
  endfunction

  function [1:0] style_field;
    input [7:0]   toff;
    input integer lsb;
    begin
      style_field = toff[lsb +: 2];
    end
  endfunction

  // Address match shared by write, read and status clear
  function addr_hit;
    input [`CPFM_ADDR_W-1:0] addr;
    input [`CPFM_ADDR_W-1:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  cpfm_ov_limit u_ov_limit (
    .setpoint_mv (setpoint_mv),
    .ov_pct      (ov_pct),
    .ov_limit_mv (ov_limit_mv)
  );

  cpfm_retry_timer #(
    .RETRY_CYCLES (RETRY_CYCLES)
  ) u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (start_timer),
    .done  (timer_done)
  );

  assign latch_sel  = cfg1_r[`CPFM_NFLT-1:0];
  assign track_diff = (vout_mv > vramp_mv) ? (vout_mv - vramp_mv) : (vramp_mv - vout_mv);

  assign trip[`CPFM_F_TR] = cfg1_r[`CPFM_BIT_TRE] && ramping_up && !track_blk_r &&
                            (track_diff > `CPFM_TRACK_MV);
  assign trip[`CPFM_F_OT] = (temp_c > `CPFM_OT_TRIP_C);
  assign trip[`CPFM_F_OC] = overcurrent_fault;
  assign trip[`CPFM_F_UV] = undervoltage_fault && !overcurrent_fault;
  assign trip[`CPFM_F_OV] = above_prebias && (vout_mv > ov_limit_mv);
  assign trip[`CPFM_F_PV] = cfg1_r[`CPFM_BIT_PVE] && phase_voltage_fault;

  assign cond[`CPFM_F_TR] = 1'b0;
  assign cond[`CPFM_F_OT] = ot_hot_r;
  assign cond[`CPFM_F_OC] = trip[`CPFM_F_OC];
  assign cond[`CPFM_F_UV] = 1'b0;
  assign cond[`CPFM_F_OV] = trip[`CPFM_F_OV];
  assign cond[`CPFM_F_PV] = trip[`CPFM_F_PV];

  assign any_trip       = |trip;
  assign cause_latching = |(cause_r & latch_sel);
  assign cause_cleared  = ~|(cause_r & cond);
  assign status_ok      = &(status_r[`CPFM_NFLT-1:0] | ~cause_r);
  assign on_recycled    = turn_on_cmd && !turn_on_d_r;
  assign wr_status      = reg_wr && addr_hit(reg_addr, `CPFM_OFS_STATUS);
  // Overtemperature alone may restart as soon as it cools once the first interval has passed
  assign ot_only        = (cause_r == ({{(`CPFM_NFLT-1){1'b0}}, 1'b1} << `CPFM_F_OT));
  assign prop_hit       = |(prop_r[`CPFM_NFLT-1:0] & (cause_r | trip));

  // Register writes and hysteresis tracking
  always @(posedge clk) begin
    if (rst) begin
      cfg1_r      <= `CPFM_CFG1_RESET;
      toff_r      <= `CPFM_TOFF_RESET;
      prop_r      <= `CPFM_PROP_RESET;
      ot_hot_r    <= 1'b0;
      turn_on_d_r <= 1'b0;
      track_blk_r <= 1'b0;
    end else begin
      turn_on_d_r <= turn_on_cmd;
      if (trip[`CPFM_F_OT])
        ot_hot_r <= 1'b1;
      else if (temp_c < `CPFM_OT_CLEAR_C)
        ot_hot_r <= 1'b0;
      if (margin_change)
        track_blk_r <= 1'b1;
      else if (!ramping_up)
        track_blk_r <= 1'b0;
      if (reg_wr) begin
        if (addr_hit(reg_addr, `CPFM_OFS_CFG1))
          cfg1_r <= reg_wdata;
        else if (addr_hit(reg_addr, `CPFM_OFS_TOFF))
          toff_r <= reg_wdata;
        else if (addr_hit(reg_addr, `CPFM_OFS_PROP))
          prop_r <= reg_wdata;
      end
    end
  end

  // Status: trip forces 0, writing 1 restores; trip wins over write
  genvar gi;
  generate
    for (gi = 0; gi < `CPFM_NFLT; gi = gi + 1) begin : g_stat
      always @(posedge clk) begin
        if (rst)
          status_r[gi] <= 1'b1;
        else if (trip[gi])
          status_r[gi] <= 1'b0;
        else if (wr_status && reg_wdata[gi])
          status_r[gi] <= 1'b1;
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (rst)
      status_r[7:`CPFM_NFLT] <= 2'b11;
    else
      status_r[7:`CPFM_NFLT] <= 2'b11;
  end

  // Register read
  always @* begin
    if (addr_hit(reg_addr, `CPFM_OFS_CFG1))
      reg_rdata = cfg1_r;
    else if (addr_hit(reg_addr, `CPFM_OFS_STATUS))
      reg_rdata = status_r;
    else if (addr_hit(reg_addr, `CPFM_OFS_TOFF))
      reg_rdata = toff_r;
    else if (addr_hit(reg_addr, `CPFM_OFS_PROP))
      reg_rdata = prop_r;
    else
      reg_rdata = 8'h00;
  end

  // Protection state machine
  always @* begin
    state_nxt   = state_r;
    style_nxt   = style_r;
    start_timer = 1'b0;
    case (state_r)
      ST_RUN: begin
        if (any_trip) begin
          style_nxt   = style_of(toff_r, trip);
          start_timer = 1'b1;
          state_nxt   = cause_latching_next(trip) ? ST_LATCH : ST_OFF;
        end
      end
      ST_OFF: begin
        if ((timer_done || (ot_only && interval_met_r)) && cause_cleared)
          state_nxt = ST_RUN;
        else if (timer_done)
          start_timer = 1'b1;
      end
      ST_LATCH: begin
        if (timer_done)
          state_nxt = ST_RAMP;
      end
      ST_RAMP: begin
        if (recycle_seen_r || on_recycled || (cause_cleared && status_ok))
          state_nxt = ST_RUN;
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  function cause_latching_next;
    input [5:0] flt;
    begin
      cause_latching_next = |(flt & latch_sel);
    end
  endfunction

  always @(posedge clk) begin
    if (rst) begin
      state_r        <= ST_RUN;
      style_r        <= `CPFM_STY_SEQ;
      cause_r        <= {`CPFM_NFLT{1'b0}};
      recycle_seen_r <= 1'b0;
      interval_met_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      style_r <= style_nxt;
      // Recycle and first-interval memory, dropped on restart
      if (state_nxt == ST_RUN) begin
        recycle_seen_r <= 1'b0;
        interval_met_r <= 1'b0;
      end else begin
        if (on_recycled)
          recycle_seen_r <= 1'b1;
        if (timer_done)
          interval_met_r <= 1'b1;
      end
      if (state_r == ST_RUN && any_trip)
        cause_r <= trip;
      else if (state_nxt == ST_RUN)
        cause_r <= {`CPFM_NFLT{1'b0}};
      else
        cause_r <= cause_r | (trip & {`CPFM_NFLT{state_r == ST_RUN}});
    end
  end

  // Power stage outputs; ST_RAMP is the latched wait after 130ms
  always @(posedge clk) begin
    if (rst) begin
      run_enable      <= 1'b0;
      ramp_down_req   <= 1'b0;
      high_side_en    <= 1'b0;
      low_side_force  <= 1'b0;
      retry_pulse     <= 1'b0;
      fault_line_out  <= 1'b0;
      fault_line_oe_n <= 1'b1;
    end else begin
      run_enable    <= (state_nxt == ST_RUN);
      retry_pulse   <= (state_r != ST_RUN) && (state_nxt == ST_RUN);
      ramp_down_req <= (state_nxt != ST_RUN) && (style_nxt == `CPFM_STY_SEQ);
      if (state_nxt == ST_RUN) begin
        high_side_en   <= 1'b1;
        low_side_force <= 1'b0;
      end else if (style_nxt == `CPFM_STY_EMER) begin
        high_side_en   <= 1'b0;
        low_side_force <= 1'b1;
      end else if (style_nxt == `CPFM_STY_CRIT) begin
        high_side_en   <= 1'b0;
        low_side_force <= 1'b0;
      end else begin
        high_side_en   <= 1'b1;
        low_side_force <= 1'b0;
      end
      fault_line_out  <= 1'b0;
      fault_line_oe_n <= !((state_nxt != ST_RUN) && prop_hit);
    end
  end

  wire unused_in = fault_line_in | cfg1_r[`CPFM_BIT_PVC];
endmodule // cpfm_fault_mgr
`default_nettype wire

// [test/cpfm_fault_mgr_props.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cpfm_defs.vh"
module cpfm_fault_mgr_props #(
  parameter [`CPFM_CNT_W-1:0] RETRY_CYCLES = 25'd20
) (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Measurements
  input wire [8:0]  temp_c,
  input wire [12:0] vout_mv,
  input wire [12:0] setpoint_mv,
  input wire [12:0] ov_limit_mv,
  input wire        above_prebias,
  input wire        ramping_up,
  input wire        overcurrent_fault,
  input wire        undervoltage_fault,
  input wire        phase_voltage_fault,
  // Power stage and fault line
  input wire        run_enable,
  input wire        ramp_down_req,
  input wire        high_side_en,
  input wire        low_side_force,
  input wire        retry_pulse,
  input wire        fault_line_out,
  input wire        fault_line_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles spent off, saturating
  logic [`CPFM_CNT_W-1:0] off_cnt;
  always @(posedge clk)
    if (rst) off_cnt <= {`CPFM_CNT_W{1'b1}};
    else if (run_enable) off_cnt <= {`CPFM_CNT_W{1'b0}};
    else if (off_cnt != {`CPFM_CNT_W{1'b1}}) off_cnt <= off_cnt + {{(`CPFM_CNT_W-1){1'b0}}, 1'b1};
  property p_oc;
    $rose(overcurrent_fault) |=> !high_side_en && !low_side_force;
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent left a switch on");
  property p_ot;
    temp_c > `CPFM_OT_TRIP_C && run_enable |=> !run_enable;
  endproperty
  a_ot: assert property (p_ot) else $error("hot controller kept running");
  property p_ov;
    above_prebias && vout_mv > ov_limit_mv && high_side_en |=> !high_side_en;
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage kept high side on");
  property p_ls;
    low_side_force |-> !high_side_en;
  endproperty
  a_ls: assert property (p_ls) else $error("both switches on");
  property p_seq;
    ramp_down_req |-> !low_side_force && !run_enable;
  endproperty
  a_seq: assert property (p_seq) else $error("ramp down with switch forced");
  property p_line;
    !fault_line_oe_n |-> !run_enable && !fault_line_out;
  endproperty
  a_line: assert property (p_line) else $error("fault line driven high");
  property p_lim;
    ov_limit_mv >= `CPFM_OV_FLOOR_MV && ov_limit_mv >= setpoint_mv + `CPFM_OV_MARGIN_MV;
  endproperty
  a_lim: assert property (p_lim) else $error("overvoltage limit too low");
  property p_idle;
    run_enable && !ramping_up && !overcurrent_fault && !undervoltage_fault && !phase_voltage_fault
      && temp_c <= `CPFM_OT_TRIP_C && vout_mv <= ov_limit_mv |=> run_enable;
  endproperty
  a_idle: assert property (p_idle) else $error("turned off without cause");
  property p_hold;
    $rose(run_enable) |-> off_cnt >= RETRY_CYCLES - 3;
  endproperty
  a_hold: assert property (p_hold) else $error("restart before interval");
  c_retry: cover property ($rose(retry_pulse));
  c_emer: cover property (low_side_force);
  c_seq: cover property (ramp_down_req);
  c_line: cover property (!fault_line_oe_n);
endmodule // cpfm_fault_mgr_props
`default_nettype wire

// [test/cpfm_mgr_model.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cpfm_defs.vh"
module cpfm_mgr_model (
  // Clock
  input  wire        clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic [7:0] reg_wdata,
  input  wire  [7:0] reg_rdata,
  // Shared fault line
  input  wire        fault_line_out,
  input  wire        fault_line_oe_n,
  output wire        fault_line
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // Pull-up on the open-drain line
  assign fault_line = fault_line_oe_n ? 1'b1 : fault_line_out;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1;
    v = reg_rdata;
  endtask
  // Status fetch for monitoring
  task automatic poll(output logic [7:0] v);
    rd(`CPFM_OFS_STATUS, v);
  endtask
endmodule // cpfm_mgr_model
`default_nettype wire

// [test/cpfm_fault_mgr_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cpfm_defs.vh"
module cpfm_fault_mgr_tb;
  localparam [`CPFM_CNT_W-1:0] RC = 25'd20;
  logic        clk = 1'b0, rst = 1'b1;
  logic [8:0]  temp_c = 9'h019;
  logic [12:0] vout_mv = 13'h3e8, vramp_mv = 13'h3e8, setpoint_mv = 13'h3e8;
  logic [7:0]  ov_pct = 8'h6e, d, prop_v = 8'h00;
  logic        above_prebias = 1'b1, ramping_up = 1'b0, margin_change = 1'b0;
  logic        oc = 1'b0, uv = 1'b0, pv = 1'b0, turn_on_cmd = 1'b0;
  wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
  wire  [12:0] ov_limit_mv;
  wire         reg_wr, run_enable, ramp_down_req, high_side_en, low_side_force;
  wire         retry_pulse, fault_line_out, fault_line_oe_n, fault_line;
  int          n_fail = 0, cmp_count = 0, n;
  int          idx[6] = '{4, 2, 1, 3, 0, 5};
  logic [12:0] sp[7] = '{13'h3e8, 13'h7d0, 13'hbb8, 13'h12c, 13'h0c8, 13'h3e8, 13'h3e8};
  logic [7:0]  pc[7] = '{8'h6e, 8'h82, 8'h6e, 8'h6e, 8'h78, 8'h8c, 8'h6e};
  logic [12:0] lim[7] = '{13'h4e2, 13'ha28, 13'hce4, 13'h226, 13'h1f4, 13'h514, 13'h4e2};
  always #2.5 clk = ~clk;
  cpfm_mgr_model M (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .fault_line_out(fault_line_out), .fault_line_oe_n(fault_line_oe_n),
    .fault_line(fault_line));
  cpfm_fault_mgr #(.RETRY_CYCLES(RC)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .temp_c(temp_c),
    .vout_mv(vout_mv), .vramp_mv(vramp_mv), .setpoint_mv(setpoint_mv), .ov_pct(ov_pct),
    .above_prebias(above_prebias), .ramping_up(ramping_up), .margin_change(margin_change),
    .overcurrent_fault(oc), .undervoltage_fault(uv), .phase_voltage_fault(pv),
    .turn_on_cmd(turn_on_cmd), .run_enable(run_enable), .ramp_down_req(ramp_down_req),
    .high_side_en(high_side_en), .low_side_force(low_side_force), .retry_pulse(retry_pulse),
    .fault_line_in(fault_line), .fault_line_out(fault_line_out),
    .fault_line_oe_n(fault_line_oe_n), .ov_limit_mv(ov_limit_mv));
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic cause(input int k, input logic on);
    @(posedge clk);
    case (k)
      0: temp_c <= on ? 9'h083 : 9'h07d;
      1: uv <= on;
      2: vout_mv <= on ? 13'h514 : 13'h3e8;
      3: oc <= on;
      4: pv <= on;
      default: begin
        ramping_up <= on;
        vramp_mv <= on ? 13'h4e3 : 13'h3e8;
      end
    endcase
  endtask
  task automatic expect_off(input int k, input int s);
    cause(k, 1'b1);
    cyc(1);
    chk("run", 0, run_enable);
    if (s != 0 || k > 1) chk("high", 0, high_side_en);
    chk("low", s == 2, low_side_force);
    chk("ramp", s == 0 && k < 2, ramp_down_req);
    chk("line", !prop_v[idx[k]], fault_line);
    M.poll(d);
    chk("status", 0, d[idx[k]]);
    cause(k, 1'b0);
  endtask
  task automatic recover(input int lo);
    n = 0;
    while (run_enable !== 1'b1 && n < 4 * RC) begin
      cyc(1);
      n++;
    end
    chk("restart", 1, run_enable);
    chk("retry", 1, retry_pulse);
    chk("interval", 1, n >= lo);
    M.wr(`CPFM_OFS_STATUS, 8'hff);
    M.poll(d);
    chk("status", 8'hff, d);
  endtask
  task automatic no_trip(input logic [7:0] c, input logic r, m, p, input logic [12:0] v);
    M.wr(`CPFM_OFS_CFG1, c);
    @(posedge clk);
    margin_change <= m;
    ramping_up <= r;
    @(posedge clk);
    margin_change <= 1'b0;
    vramp_mv <= v;
    pv <= p;
    cyc(4);
    chk("run", 1, run_enable);
    @(posedge clk);
    ramping_up <= 1'b0;
    vramp_mv <= 13'h3e8;
    pv <= 1'b0;
  endtask
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #60000;
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    chk("run", 1, run_enable);
    M.rd(`CPFM_OFS_CFG1, d);
    chk("cfg1", 8'h43, d);
    M.poll(d);
    chk("status", 8'hff, d);
    M.rd(8'h10, d);
    chk("unmapped", 0, d);
    @(posedge clk) above_prebias <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      setpoint_mv <= sp[i];
      ov_pct <= pc[i];
      cyc(1);
      chk("ov_limit", lim[i], ov_limit_mv);
    end
    chk("run", 1, run_enable);
    @(posedge clk) above_prebias <= 1'b1;
    no_trip(8'hc0, 1'b1, 1'b0, 1'b0, 13'h4e2);
    no_trip(8'hc0, 1'b0, 1'b0, 1'b0, 13'h578);
    no_trip(8'h40, 1'b1, 1'b0, 1'b0, 13'h578);
    no_trip(8'h80, 1'b0, 1'b0, 1'b1, 13'h3e8);
    no_trip(8'hc0, 1'b1, 1'b1, 1'b0, 13'h578);
    for (int k = 0; k < 3; k++)
      for (int s = 0; s < 3; s++) begin
        M.wr(`CPFM_OFS_TOFF, 8'(s << (2 * k)));
        expect_off(k, s);
        if (k == 0) begin
          cyc(2 * RC);
          chk("ot hold", 0, run_enable);
          @(posedge clk) temp_c <= 9'h077;
        end
        recover(k == 0 ? 0 : RC - 8);
      end
    for (int k = 3; k < 6; k++) begin
      expect_off(k, 1);
      recover(RC - 8);
    end
    M.wr(`CPFM_OFS_CFG1, 8'hc8);
    M.rd(`CPFM_OFS_CFG1, d);
    chk("cfg1", 8'hc8, d);
    for (int j = 0; j < 2; j++) begin
      expect_off(3, 1);
      cyc(2 * RC);
      chk("latched", 0, run_enable);
      if (j == 0) M.wr(`CPFM_OFS_STATUS, 8'hff);
      else @(posedge clk) turn_on_cmd <= 1'b1;
      recover(0);
    end
    M.wr(`CPFM_OFS_CFG1, 8'hc0);
    prop_v = 8'h08;
    M.wr(`CPFM_OFS_PROP, prop_v);
    M.rd(`CPFM_OFS_PROP, d);
    chk("prop", 8'h08, d);
    expect_off(3, 1);
    recover(RC - 8);
    complete_run;
  end
endmodule // cpfm_fault_mgr_tb
bind cpfm_fault_mgr cpfm_fault_mgr_props #(.RETRY_CYCLES(RETRY_CYCLES)) u_props (.clk(clk), .rst(rst),
  .temp_c(temp_c), .vout_mv(vout_mv), .setpoint_mv(setpoint_mv), .ov_limit_mv(ov_limit_mv),
  .above_prebias(above_prebias), .ramping_up(ramping_up), .overcurrent_fault(overcurrent_fault),
  .undervoltage_fault(undervoltage_fault), .phase_voltage_fault(phase_voltage_fault),
  .run_enable(run_enable), .ramp_down_req(ramp_down_req), .high_side_en(high_side_en),
  .low_side_force(low_side_force), .retry_pulse(retry_pulse), .fault_line_out(fault_line_out),
  .fault_line_oe_n(fault_line_oe_n));
`default_nettype wire
